// [shared/pdm_pkg.sv]
// Constants, types and register map of the power-down mode controller.
// How it works
// - Sleep with standby and deep sleep select clear: halt CPU, keep clocks and refresh.
// - Sleep with standby select set: halt clocks, CPU, peripherals; self-refresh.
// - Standby clear and deep sleep set: halt CPU and DMA, self-refresh.
// - Any accepted interrupt or reset leaves the low-power state and resumes.
// - Deep sleep select is bit 7 of the second register, only without standby.
// - State pins: reset HH, sleep HL, standby LH, normal LL.
// - First register is 8-bit read/write, cleared by reset or watchdog overflow.
// - Registers at 0xffc00004 and 0xffc00010, mirrored in area 7, byte wide.
// - Pin float bit 6 set puts peripheral pins in high impedance in standby.
// - Pull-up bit 5 clear enables pull-ups; set disables them.
// - Bit 4 set stops the DMA controller clock.
// - Bit 3 set stops the second serial channel clock.
// - Bit 2 set stops the timer unit clock.
// - Bit 1 set blocks clock calendar register access; its counters run on.
// - Bit 0 set stops the first serial channel clock.
package pdm_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [31:0] ADDR_STANDBY_CTRL_REG = 32'hffc00004;
  localparam logic [31:0] ADDR_STANDBY_CTRL_REG_SECOND = 32'hffc00010;
  localparam logic [2:0] REGION_P4 = 3'h7;
  localparam logic [2:0] REGION_AREA7 = 3'h0;
  localparam logic [7:0] STANDBY_CTRL_RST = 8'h00;
  localparam logic [7:0] STANDBY_CTRL_SECOND_RST = 8'h00;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int PIN_FLOAT_BIT = 6;
  localparam int PULLUP_DISABLE_BIT = 5;
  localparam int MSTP_DMA_BIT = 4;
  localparam int MSTP_SER2_BIT = 3;
  localparam int MSTP_TMR_BIT = 2;
  localparam int MSTP_RTC_BIT = 1;
  localparam int MSTP_SER1_BIT = 0;
  localparam int DEEP_SLEEP_SELECT_BIT = 7;

  // ------------------------------------------------------------
  // Processor state pin codes, upper bit first
  // ------------------------------------------------------------
  localparam logic [1:0] PST_RESET = 2'h3;
  localparam logic [1:0] PST_SLEEP = 2'h2;
  localparam logic [1:0] PST_STANDBY = 2'h1;
  localparam logic [1:0] PST_RUN = 2'h0;

  // ------------------------------------------------------------
  // Synchroniser and types
  // ------------------------------------------------------------
  localparam int SYNC_W = 5;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h00;

  typedef enum logic [2:0] {
    PDM_RESET,
    PDM_RUN,
    PDM_SLEEP,
    PDM_DEEP,
    PDM_STANDBY
  } pdm_mode_t;

  typedef struct packed {
    logic cpu_halt;
    logic clk_gen_run;
    logic dma_clk_en;
    logic ser2_clk_en;
    logic tmr_clk_en;
    logic ser1_clk_en;
    logic rtc_access_en;
    logic pin_hiz;
    logic pullup_en;
    logic mem_refresh;
    logic mem_self_refresh;
  } pdm_ctl_t;

  localparam pdm_ctl_t CTL_RST = '{
    cpu_halt: 1'b0, clk_gen_run: 1'b1, dma_clk_en: 1'b1,
    ser2_clk_en: 1'b1, tmr_clk_en: 1'b1, ser1_clk_en: 1'b1,
    rtc_access_en: 1'b1, pin_hiz: 1'b0, pullup_en: 1'b1,
    mem_refresh: 1'b1, mem_self_refresh: 1'b0
  };

  typedef struct packed {
    logic nmi;
    logic [3:0] irl;
  } pdm_wake_t;

endpackage

// [src/pdm_sync.sv]
// Three-stage synchroniser for the wake-up pins.
module pdm_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous pins in
  input wire logic [pdm_pkg::SYNC_W-1:0] pin_in,
  // Settled levels out
  output logic [pdm_pkg::SYNC_W-1:0] level
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [pdm_pkg::SYNC_W-1:0] s1;
    logic [pdm_pkg::SYNC_W-1:0] s2;
    logic [pdm_pkg::SYNC_W-1:0] s3;
    logic [pdm_pkg::SYNC_W-1:0] lvl;
  } pdm_sync_st_t;

  pdm_sync_st_t st_q;
  pdm_sync_st_t st_d;

  // A level is accepted only once two late stages agree, which
  // filters a change caught mid-way through metastability.
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < pdm_pkg::SYNC_W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= '{pdm_pkg::SYNC_RST, pdm_pkg::SYNC_RST,
                pdm_pkg::SYNC_RST, pdm_pkg::SYNC_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;

endmodule

// [src/pdm_ctrl.sv]
// Power-down mode controller: registers, mode sequencer, gating outputs.
//
// Strobed register access is this design's own decision.
module pdm_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Watchdog overflow reset, same clock
  input wire logic wdt_overflow,
  // Register port
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // CPU core handshake
  input wire logic sleep_done,
  output logic cpu_resume,
  // Wake sources
  input wire pdm_pkg::pdm_wake_t wake_pins,
  input wire logic periph_irq,
  // Processor state pins
  output logic proc_state_hi,
  output logic proc_state_lo,
  // Clock, pin and memory controls
  output pdm_pkg::pdm_ctl_t ctl
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------

  // Matches an address in the P4 region or its area 7 mirror.
  function automatic logic hit(input logic [31:0] a,
                               input logic [31:0] base);
    logic region_ok;
    region_ok = (a[31:29] == pdm_pkg::REGION_P4) ||
                (a[31:29] == pdm_pkg::REGION_AREA7);
    return region_ok && (a[28:0] == base[28:0]);
  endfunction

  // Builds the gating controls for a given mode and register value.
  function automatic pdm_pkg::pdm_ctl_t gate(
      input pdm_pkg::pdm_mode_t m,
      input logic [7:0] cr);
    pdm_pkg::pdm_ctl_t c;
    logic standby;
    logic deep;
    logic halt;
    c = pdm_pkg::CTL_RST;
    standby = (m == pdm_pkg::PDM_STANDBY);
    deep = (m == pdm_pkg::PDM_DEEP);
    halt = (m == pdm_pkg::PDM_SLEEP) || deep || standby;
    c.cpu_halt = halt;
    c.clk_gen_run = !standby;
    c.dma_clk_en = !cr[pdm_pkg::MSTP_DMA_BIT] && !standby && !deep;
    c.ser2_clk_en = !cr[pdm_pkg::MSTP_SER2_BIT] && !standby;
    c.tmr_clk_en = !cr[pdm_pkg::MSTP_TMR_BIT] && !standby;
    c.rtc_access_en = !cr[pdm_pkg::MSTP_RTC_BIT] && !standby;
    c.ser1_clk_en = !cr[pdm_pkg::MSTP_SER1_BIT] && !standby;
    c.pin_hiz = standby && cr[pdm_pkg::PIN_FLOAT_BIT];
    c.pullup_en = !cr[pdm_pkg::PULLUP_DISABLE_BIT];
    c.mem_self_refresh = deep || standby;
    c.mem_refresh = !(deep || standby);
    return c;
  endfunction

  // ------------------------------------------------------------
  // Wake pin synchroniser
  // ------------------------------------------------------------
  logic [pdm_pkg::SYNC_W-1:0] wake_lvl;

  pdm_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(wake_pins),
    .level(wake_lvl)
  );

  pdm_pkg::pdm_wake_t wake_s;
  assign wake_s = wake_lvl;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    pdm_pkg::pdm_mode_t mode;
    logic [7:0] sctl;
    logic deep_sel;
    logic [7:0] rdata;
    logic resume;
    logic [1:0] pstate;
    pdm_pkg::pdm_ctl_t ctl;
  } pdm_st_t;

  pdm_st_t st_q;
  pdm_st_t st_d;

  logic wake;
  logic wr_cr;
  logic wr_cr2;
  logic rd_cr;
  logic rd_cr2;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------

  assign wr_cr = wr_en && hit(addr, pdm_pkg::ADDR_STANDBY_CTRL_REG);
  assign wr_cr2 = wr_en && hit(addr, pdm_pkg::ADDR_STANDBY_CTRL_REG_SECOND);
  assign rd_cr = rd_en && hit(addr, pdm_pkg::ADDR_STANDBY_CTRL_REG);
  assign rd_cr2 = rd_en && hit(addr, pdm_pkg::ADDR_STANDBY_CTRL_REG_SECOND);

  // NMI is edge-free here: a held request keeps the core awake,
  // which is safe because the core clears its source on service.
  // Wake event
  assign wake = wake_s.nmi || (wake_s.irl != 4'h0) || periph_irq;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.resume = 1'b0;
    st_d.rdata = 8'h00;

    // Register writes land in any mode; only a running core
    // issues them, so no mode needs to arbitrate.
    // Read/write register
    if (wr_cr) begin
      st_d.sctl = wdata;
    end
    if (wr_cr2) begin
      st_d.deep_sel = wdata[pdm_pkg::DEEP_SLEEP_SELECT_BIT];
    end

    // Unmapped addresses read as zero.
    if (rd_cr) begin
      st_d.rdata = st_q.sctl;
    end else if (rd_cr2) begin
      st_d.rdata[pdm_pkg::DEEP_SLEEP_SELECT_BIT] = st_q.deep_sel;
    end

    unique case (st_q.mode)
      pdm_pkg::PDM_RESET: begin
        st_d.mode = pdm_pkg::PDM_RUN;
      end
      pdm_pkg::PDM_RUN: begin
        if (sleep_done) begin
          if (st_q.sctl[pdm_pkg::STANDBY_SELECT_BIT]) begin
            st_d.mode = pdm_pkg::PDM_STANDBY;
          end else if (st_q.deep_sel) begin
            st_d.mode = pdm_pkg::PDM_DEEP;
          end else begin
            st_d.mode = pdm_pkg::PDM_SLEEP;
          end
        end
      end
      pdm_pkg::PDM_SLEEP,
      pdm_pkg::PDM_DEEP,
      pdm_pkg::PDM_STANDBY: begin
        if (wake) begin
          st_d.mode = pdm_pkg::PDM_RUN;
          st_d.resume = 1'b1;
        end
      end
    endcase

    unique case (st_d.mode)
      pdm_pkg::PDM_RESET: st_d.pstate = pdm_pkg::PST_RESET;
      pdm_pkg::PDM_SLEEP: st_d.pstate = pdm_pkg::PST_SLEEP;
      pdm_pkg::PDM_DEEP: st_d.pstate = pdm_pkg::PST_SLEEP;
      pdm_pkg::PDM_STANDBY: st_d.pstate = pdm_pkg::PST_STANDBY;
      pdm_pkg::PDM_RUN: st_d.pstate = pdm_pkg::PST_RUN;
    endcase

    st_d.ctl = gate(st_d.mode, st_d.sctl);

    // Watchdog overflow is a power-on reset for this block: it
    // clears the registers and shows the reset code for a cycle.
    // Watchdog clears
    if (wdt_overflow) begin
      st_d.mode = pdm_pkg::PDM_RESET;
      st_d.sctl = pdm_pkg::STANDBY_CTRL_RST;
      st_d.deep_sel = pdm_pkg::STANDBY_CTRL_SECOND_RST[pdm_pkg::DEEP_SLEEP_SELECT_BIT];
      st_d.resume = 1'b0;
      st_d.pstate = pdm_pkg::PST_RESET;
      st_d.ctl = pdm_pkg::CTL_RST;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q.mode <= pdm_pkg::PDM_RESET;
      st_q.sctl <= pdm_pkg::STANDBY_CTRL_RST;
      st_q.deep_sel <= 1'b0;
      st_q.rdata <= 8'h00;
      st_q.resume <= 1'b0;
      st_q.pstate <= pdm_pkg::PST_RESET;
      st_q.ctl <= pdm_pkg::CTL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata = st_q.rdata;
  assign cpu_resume = st_q.resume;
  assign proc_state_hi = st_q.pstate[1];
  assign proc_state_lo = st_q.pstate[0];
  assign ctl = st_q.ctl;

endmodule

// [tb/pdm_ctrl_sva.sv]
// Port checker of the power-down mode controller.
module pdm_ctrl_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Watched ports
  input wire logic wdt_overflow,
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic sleep_done,
  input wire logic cpu_resume,
  input wire pdm_pkg::pdm_wake_t wake_pins,
  input wire logic periph_irq,
  input wire logic proc_state_hi,
  input wire logic proc_state_lo,
  input wire pdm_pkg::pdm_ctl_t ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Properties
  // ----------
  wire logic [1:0] ps = {proc_state_hi, proc_state_lo};
  wire logic run = ps == pdm_pkg::PST_RUN;
  wire logic stb = ps == pdm_pkg::PST_STANDBY;
  wire logic low = stb || ps == pdm_pkg::PST_SLEEP;
  wire logic a1 = addr[28:0] == pdm_pkg::ADDR_STANDBY_CTRL_REG[28:0] &&
    (addr[31:29] == pdm_pkg::REGION_P4 || addr[31:29] == pdm_pkg::REGION_AREA7);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_wdt;
    wdt_overflow ##1 !wdt_overflow |-> ps == pdm_pkg::PST_RESET ##1 run;
  endproperty
  a_wdt: assert property (p_wdt) else $error("bad watchdog reset");
  property p_enter;
    sleep_done && run && !wdt_overflow |=> low && ctl.cpu_halt;
  endproperty
  a_enter: assert property (p_enter) else $error("no entry");
  property p_standby_select;
    stb |-> !ctl.clk_gen_run && !ctl.dma_clk_en && !ctl.ser1_clk_en && ctl.mem_self_refresh;
  endproperty
  a_standby_select: assert property (p_standby_select) else $error("standby controls");
  property p_low;
    low && !stb |-> ctl.clk_gen_run && ctl.cpu_halt && !ctl.pin_hiz;
  endproperty
  a_low: assert property (p_low) else $error("sleep controls");
  property p_wake;
    low && periph_irq && !wdt_overflow |=> run && cpu_resume && !ctl.cpu_halt;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_pulse;
    cpu_resume |-> run && $past(low) ##1 !cpu_resume;
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad resume");
  property p_idle;
    !rd_en |=> rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_wr_rd;
    wr_en && a1 && !wdt_overflow ##1 !wr_en && !wdt_overflow ##1 rd_en && a1
      |=> rdata == $past(wdata, 3);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback");
  c_sleep: cover property (sleep_done && run);
  c_standby_select: cover property (stb);
  c_wake: cover property (cpu_resume);
endmodule
bind pdm_ctrl pdm_ctrl_sva u_sva (.clock(clock), .rst_n(rst_n), .wdt_overflow(wdt_overflow),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .sleep_done(sleep_done), .cpu_resume(cpu_resume), .wake_pins(wake_pins),
  .periph_irq(periph_irq), .proc_state_hi(proc_state_hi), .proc_state_lo(proc_state_lo),
  .ctl(ctl));

// [tb/pdm_cpu_model.sv]
// CPU core model that reports the end of a sleep instruction.
module pdm_cpu_model (
  // Clock
  input wire logic clock,
  // Request and delay
  input wire logic go,
  input wire logic [3:0] dly,
  // Completion
  output logic sleep_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q = 5'h00;
  initial sleep_done = 1'b0;
  // One-cycle completion pulse
  // A slow core ends its instruction late, so entry must wait for it.
  always @(posedge clock) begin
    sleep_done <= cnt_q == 5'h01;
    cnt_q <= go ? {1'b0, dly} + 5'h01 : cnt_q - {4'h0, cnt_q != 5'h00};
  end
endmodule

// [tb/pdm_ctrl_test.sv]
// Self-checking bench of the power-down mode controller.
`define CHK(g, w) begin compares++; if ((g) !== (w)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, w); end end
module pdm_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wdt_overflow = 1'b0;
  logic [31:0] addr = 32'h00000000;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic go = 1'b0;
  logic [3:0] dly = 4'h0;
  logic periph_irq = 1'b0;
  pdm_pkg::pdm_wake_t wake_pins = '0;
  logic sleep_done;
  logic cpu_resume;
  logic [7:0] rdata;
  logic proc_state_hi;
  logic proc_state_lo;
  pdm_pkg::pdm_ctl_t ctl;
  wire logic [1:0] ps = {proc_state_hi, proc_state_lo};
  int n_fail = 0;
  int compares = 0;
  int i;
  logic [7:0] v;
  logic standby;
  logic deep;
  logic [1:0] exp_ps;
  logic [7:0] t1 [4] = '{8'h00, 8'h00, 8'hc0, 8'h80};
  logic [7:0] t2 [4] = '{8'h00, 8'h80, 8'h80, 8'h00};
  pdm_ctrl dut (.clock(clock), .rst_n(rst_n), .wdt_overflow(wdt_overflow), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sleep_done(sleep_done),
    .cpu_resume(cpu_resume), .wake_pins(wake_pins), .periph_irq(periph_irq),
    .proc_state_hi(proc_state_hi), .proc_state_lo(proc_state_lo), .ctl(ctl));
  pdm_cpu_model cpu (.clock(clock), .go(go), .dly(dly), .sleep_done(sleep_done));
  initial begin
    forever #2 clock = ~clock;
  end
  // ----------
  // Tasks
  // ----------
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge clock);
  endtask
  // Bounded wait, since a stuck mode must not hang the run.
  task automatic wait_ps(input logic [1:0] e);
    for (int k = 0; k < 24 && ps !== e; k++) begin
      @(posedge clock);
      #1;
    end
    `CHK(ps, e)
  endtask
  initial begin
    #20000;
    n_fail++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge clock);
    #1;
    `CHK(ps, pdm_pkg::PST_RESET)
    repeat (9) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    `CHK(ps, pdm_pkg::PST_RUN)
    @(posedge clock);
    rd(pdm_pkg::ADDR_STANDBY_CTRL_REG, 8'h00);
    rd(pdm_pkg::ADDR_STANDBY_CTRL_REG_SECOND, 8'h00);
    wr(pdm_pkg::ADDR_STANDBY_CTRL_REG_SECOND, 8'hff);
    rd(32'h1fc00010, 8'h80);
    wr(32'hffc00008, 8'h5a);
    rd(32'hffc00008, 8'h00);
    // No DMA traffic runs here while its clock is stopped.
    for (i = 0; i < 7; i++) begin
      v = 8'h01 << i;
      wr(32'h1fc00004, v);
      rd(pdm_pkg::ADDR_STANDBY_CTRL_REG, v);
      #1;
      `CHK({ctl.dma_clk_en, ctl.ser2_clk_en, ctl.tmr_clk_en}, ~v[4:2])
      `CHK({ctl.rtc_access_en, ctl.ser1_clk_en}, ~v[1:0])
      `CHK(ctl.pullup_en, !v[5])
      `CHK(ctl.pin_hiz, 1'b0)
      @(posedge clock);
    end
    for (i = 0; i < 4; i++) begin
      wr(pdm_pkg::ADDR_STANDBY_CTRL_REG, t1[i]);
      wr(pdm_pkg::ADDR_STANDBY_CTRL_REG_SECOND, t2[i]);
      standby = t1[i][7];
      deep = !standby && t2[i][7];
      exp_ps = standby ? pdm_pkg::PST_STANDBY : pdm_pkg::PST_SLEEP;
      dly <= 4'(i * 4);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
      #1;
      `CHK(ps, pdm_pkg::PST_RUN)
      wait_ps(exp_ps);
      `CHK(ctl.cpu_halt, 1'b1)
      `CHK(ctl.clk_gen_run, !standby)
      `CHK(ctl.tmr_clk_en, !standby)
      `CHK(ctl.dma_clk_en, !(standby || deep))
      `CHK(ctl.mem_self_refresh, standby || deep)
      `CHK(ctl.mem_refresh, !(standby || deep))
      `CHK(ctl.pin_hiz, standby && t1[i][6])
      repeat (6) @(posedge clock);
      #1;
      `CHK(ps, exp_ps)
      @(posedge clock);
      periph_irq <= !i[0];
      wake_pins <= '{nmi: i == 1, irl: (i == 3) ? 4'h9 : 4'h0};
      wait_ps(pdm_pkg::PST_RUN);
      `CHK(cpu_resume, 1'b1)
      @(posedge clock);
      periph_irq <= 1'b0;
      wake_pins <= '0;
      repeat (6) @(posedge clock);
    end
    wr(pdm_pkg::ADDR_STANDBY_CTRL_REG, 8'h1f);
    wdt_overflow <= 1'b1;
    @(posedge clock);
    wdt_overflow <= 1'b0;
    #1;
    `CHK(ps, pdm_pkg::PST_RESET)
    @(posedge clock);
    rd(pdm_pkg::ADDR_STANDBY_CTRL_REG, 8'h00);
    close_out;
  end
endmodule
